// ==== inc/sepc_params.svh ====
// Constants of the serial EEPROM command and protection block.
// Included by the design file; holds definitions only.
`ifndef SEPC_PARAMS_SVH
`define SEPC_PARAMS_SVH

// Instruction encodings.
`define SEPC_OP_SET_WL    8'h06
`define SEPC_OP_CLR_WL    8'h04
`define SEPC_OP_RD_STAT   8'h05
`define SEPC_OP_WR_STAT   8'h01
`define SEPC_OP_READ      8'h03
`define SEPC_OP_WRITE     8'h02
`define SEPC_OP_ADDR_MASK 8'hf7
`define SEPC_OP_ADDR_BIT  3

// Status byte field positions.
`define SEPC_SR_BUSY      0
`define SEPC_SR_WL        1
`define SEPC_SR_GUARD_LO  2
`define SEPC_SR_GUARD_HI  3
`define SEPC_SR_LOCK      4
`define SEPC_SR_IDSEL     6

// Reset values of the status fields.
`define SEPC_GUARD_RST    2'h0
`define SEPC_LOCK_RST     1'h1
`define SEPC_IDSEL_RST    1'h1

// Block guard codes.
`define SEPC_GUARD_NONE   2'h0
`define SEPC_GUARD_QUART  2'h1
`define SEPC_GUARD_HALF   2'h2
`define SEPC_GUARD_FULL   2'h3

// Page and identification page geometry.
`define SEPC_PAGE_BITS    4
`define SEPC_PAGE_BYTES   16

// Timing: program cycle time and system clock period.
`define SEPC_PROG_TIME_US  4000
`define SEPC_CLK_PERIOD_NS 20
`define SEPC_PROG_CYCLES   ((`SEPC_PROG_TIME_US * 1000) / `SEPC_CLK_PERIOD_NS)

`endif

// ==== inc/sepc_pkg.sv ====
// Types of the serial EEPROM command and protection block.
// No dependencies.
package sepc_pkg;

  // Frame phase on the serial side, one-hot.
  typedef enum logic [6:0] {
    ST_OPCODE    = 7'h01,
    ST_ADDR      = 7'h02,
    ST_DATA      = 7'h04,
    ST_STAT_DATA = 7'h08,
    ST_READ_OUT  = 7'h10,
    ST_STAT_OUT  = 7'h20,
    ST_IGNORE    = 7'h40
  } sepc_state_e;

  // Command recognised in the current or last frame, one-hot.
  typedef enum logic [6:0] {
    K_NONE    = 7'h01,
    K_SET_WL  = 7'h02,
    K_CLR_WL  = 7'h04,
    K_WR_STAT = 7'h08,
    K_WRITE   = 7'h10,
    K_READ    = 7'h20,
    K_RD_STAT = 7'h40
  } sepc_kind_e;

endpackage

// ==== rtl/sepc_command_protect.sv ====
// Command decoder, status register and write protection of a serial
// EEPROM with a 16-byte identification page, SPI modes 0 and 3.
// Assumes sck, cs_n, si, wp_n and hold_n come straight from pins and
// clk is a free running system clock with a synchronous high reset.
`timescale 1ns/1ps
`include "sepc_params.svh"

module sepc_command_protect #(
  parameter int ADDR_W      = 9,
  parameter int PROG_CYCLES = `SEPC_PROG_CYCLES
) (
  // System clock and reset.
  input  wire logic clk,
  input  wire logic reset,
  // Serial link from the host.
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  output logic      so_o,
  output logic      so_oe,
  // Control pins.
  input  wire logic wp_n,
  input  wire logic hold_n
);

  localparam int MEM_BYTES = 1 << ADDR_W;
  localparam int PB        = `SEPC_PAGE_BITS;
  localparam int CW        = $clog2(PROG_CYCLES + 1);

  // Refuse geometries and counts the logic cannot serve.
  if (ADDR_W < 8 || ADDR_W > 9)
  begin : g_bad_addr
    $error("ADDR_W must be 8 or 9");
  end
  if (PROG_CYCLES < 1)
  begin : g_bad_prog
    $error("PROG_CYCLES must be at least one");
  end

  // Storage: main array and identification page.
  logic [7:0] mem_arr [MEM_BYTES];
  logic [7:0] id_arr  [`SEPC_PAGE_BYTES];
  logic [7:0] page_buf[`SEPC_PAGE_BYTES];

  // Serial side frame state.
  sepc_pkg::sepc_state_e state_reg;
  logic [2:0]            bit_cnt_reg;
  logic [6:0]            shift_reg;
  logic [ADDR_W-1:0]     ptr_reg;
  logic                  a8_reg;
  logic [7:0]            out_byte_reg;
  logic                  out_load_reg;
  logic [6:0]            out_sh_reg;
  logic                  so_reg;
  logic                  drive_reg;
  logic [7:0]            stat_s1_reg;
  logic [7:0]            stat_s2_reg;

  // Serial side results held for the system side after the frame.
  logic                  tog_reg;
  sepc_pkg::sepc_kind_e  kind_reg;
  logic                  aligned_reg;
  logic [15:0]           mask_reg;
  logic [ADDR_W-1:0]     start_reg;
  logic [7:0]            sr_data_reg;

  // System side state.
  logic                  cs_s1_reg;
  logic                  cs_s2_reg;
  logic                  cs_s3_reg;
  logic                  wp_s1_reg;
  logic                  wp_s2_reg;
  logic                  tog_s1_reg;
  logic                  tog_s2_reg;
  logic                  tog_seen_reg;
  logic                  busy_reg;
  logic [CW-1:0]         cnt_reg;
  logic                  wl_reg;
  logic [1:0]            guard_reg;
  logic                  lock_reg;
  logic                  idsel_reg;

  // Combinational helpers.
  logic [7:0]            byte_in;
  logic                  byte_done;
  logic                  busy_sck;
  logic                  idsel_sck;
  sepc_pkg::sepc_kind_e  op_kind;
  logic [ADDR_W-1:0]     addr_full;
  logic [ADDR_W-1:0]     rd_addr;
  logic [7:0]            rd_data;
  logic [7:0]            status_byte;
  logic                  commit;
  logic                  wr_ok;
  logic                  guarded;
  logic                  write_go;
  logic                  stat_go;
  logic                  prog_done;

  // Status byte as software sees it.
  // status layout
  assign status_byte = {1'b1, idsel_reg, 1'b1, lock_reg, guard_reg,
                        wl_reg, busy_reg};

  // Incoming byte, its completion and the synchronised status view.
  assign byte_in   = {shift_reg, si};
  assign byte_done = (bit_cnt_reg == 3'h7);
  assign busy_sck  = stat_s2_reg[`SEPC_SR_BUSY];
  assign idsel_sck = stat_s2_reg[`SEPC_SR_IDSEL];
  assign addr_full = ADDR_W'({a8_reg, byte_in});

  // Opcode decode; with ADDR_W of 9, bit 3 of read and write is an address bit.
  always_comb
  begin
    op_kind = sepc_pkg::K_NONE;
    if (byte_in == `SEPC_OP_SET_WL)
      op_kind = sepc_pkg::K_SET_WL;
    else if (byte_in == `SEPC_OP_CLR_WL)
      op_kind = sepc_pkg::K_CLR_WL;
    else if (byte_in == `SEPC_OP_RD_STAT)
      op_kind = sepc_pkg::K_RD_STAT;
    else if (byte_in == `SEPC_OP_WR_STAT)
      op_kind = sepc_pkg::K_WR_STAT;
    else if (ADDR_W > 8 &&
             (byte_in & `SEPC_OP_ADDR_MASK) == `SEPC_OP_READ)
      op_kind = sepc_pkg::K_READ;
    else if (ADDR_W > 8 &&
             (byte_in & `SEPC_OP_ADDR_MASK) == `SEPC_OP_WRITE)
      op_kind = sepc_pkg::K_WRITE;
    else if (byte_in == `SEPC_OP_READ)
      op_kind = sepc_pkg::K_READ;
    else if (byte_in == `SEPC_OP_WRITE)
      op_kind = sepc_pkg::K_WRITE;
    if (busy_sck && op_kind != sepc_pkg::K_RD_STAT)
      op_kind = sepc_pkg::K_NONE;
  end

  // Read source: array or id page; the content is quiet while reads run.
  always_comb
  begin
    rd_addr = (state_reg == sepc_pkg::ST_ADDR) ? addr_full : ptr_reg;
    if (idsel_sck)
      rd_data = mem_arr[rd_addr];
    else
      rd_data = id_arr[rd_addr[PB-1:0]];
  end

  // Status view brought over to the serial clock.
  always_ff @(posedge sck)
  begin
    stat_s1_reg <= status_byte;
    stat_s2_reg <= stat_s1_reg;
  end

  // Frame sequencer on rising sck, cleared whenever chip select is high.
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      state_reg    <= sepc_pkg::ST_OPCODE;
      bit_cnt_reg  <= 3'h0;
      shift_reg    <= 7'h00;
      ptr_reg      <= '0;
      a8_reg       <= 1'b0;
      out_byte_reg <= 8'h00;
      out_load_reg <= 1'b0;
    end
    else if (hold_n)
    begin
      bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      shift_reg    <= byte_in[6:0];
      out_load_reg <= 1'b0;
      if (byte_done)
      begin
        unique case (state_reg)
          sepc_pkg::ST_OPCODE:
          begin
            a8_reg <= byte_in[`SEPC_OP_ADDR_BIT];
            unique case (op_kind)
              sepc_pkg::K_RD_STAT:
              begin
                state_reg    <= sepc_pkg::ST_STAT_OUT;
                out_byte_reg <= stat_s2_reg;
                out_load_reg <= 1'b1;
              end
              sepc_pkg::K_WR_STAT: state_reg <= sepc_pkg::ST_STAT_DATA;
              sepc_pkg::K_READ:    state_reg <= sepc_pkg::ST_ADDR;
              sepc_pkg::K_WRITE:   state_reg <= sepc_pkg::ST_ADDR;
              default:             state_reg <= sepc_pkg::ST_IGNORE;
            endcase
          end
          sepc_pkg::ST_ADDR:
          begin
            if (kind_reg == sepc_pkg::K_READ)
            begin
              state_reg    <= sepc_pkg::ST_READ_OUT;
              out_byte_reg <= rd_data;
              out_load_reg <= 1'b1;
              ptr_reg      <= rd_addr + ADDR_W'(1);
            end
            else
            begin
              state_reg <= sepc_pkg::ST_DATA;
              ptr_reg   <= addr_full;
            end
          end
          sepc_pkg::ST_DATA:
            ptr_reg <= {ptr_reg[ADDR_W-1:PB], ptr_reg[PB-1:0] + 4'h1};
          sepc_pkg::ST_STAT_DATA: state_reg <= sepc_pkg::ST_IGNORE;
          sepc_pkg::ST_READ_OUT:
          begin
            out_byte_reg <= rd_data;
            out_load_reg <= 1'b1;
            ptr_reg      <= rd_addr + ADDR_W'(1);
          end
          sepc_pkg::ST_STAT_OUT:
          begin
            out_byte_reg <= stat_s2_reg;
            out_load_reg <= 1'b1;
          end
          sepc_pkg::ST_IGNORE: state_reg <= sepc_pkg::ST_IGNORE;
        endcase
      end
    end
  end

  // Frame results that outlive chip select, for the system side.
  always_ff @(posedge sck or posedge reset)
  begin
    if (reset)
    begin
      tog_reg     <= 1'b0;
      kind_reg    <= sepc_pkg::K_NONE;
      aligned_reg <= 1'b0;
      mask_reg    <= 16'h0000;
      start_reg   <= '0;
      sr_data_reg <= 8'h00;
    end
    else if (!cs_n && hold_n)
    begin
      aligned_reg <= byte_done;
      if (state_reg == sepc_pkg::ST_OPCODE && bit_cnt_reg == 3'h0)
      begin
        // A new frame: announce it and forget the previous command and byte mask.
        tog_reg  <= ~tog_reg;
        kind_reg <= sepc_pkg::K_NONE;
        mask_reg <= 16'h0000;
      end
      if (state_reg == sepc_pkg::ST_IGNORE)
        kind_reg <= sepc_pkg::K_NONE;
      if (byte_done)
      begin
        if (state_reg == sepc_pkg::ST_OPCODE)
          kind_reg <= op_kind;
        if (state_reg == sepc_pkg::ST_ADDR)
          start_reg <= addr_full;
        if (state_reg == sepc_pkg::ST_DATA)
          mask_reg[ptr_reg[PB-1:0]] <= 1'b1;
        if (state_reg == sepc_pkg::ST_STAT_DATA)
          sr_data_reg <= byte_in;
      end
    end
  end

  // Page buffer, filled by address low bits.
  always_ff @(posedge sck)
  begin
    if (!cs_n && hold_n && byte_done && state_reg == sepc_pkg::ST_DATA)
      page_buf[ptr_reg[PB-1:0]] <= byte_in;
  end

  // Output shifter on falling sck.
  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      so_reg     <= 1'b0;
      out_sh_reg <= 7'h00;
      drive_reg  <= 1'b0;
    end
    else if (hold_n)
    begin
      if (out_load_reg)
      begin
        so_reg     <= out_byte_reg[7];
        out_sh_reg <= out_byte_reg[6:0];
        drive_reg  <= 1'b1;
      end
      else
      begin
        so_reg     <= out_sh_reg[6];
        out_sh_reg <= {out_sh_reg[5:0], 1'b0};
      end
    end
  end

  // Output pin: driven only in output phases, selected and not paused.
  // output float
  assign so_oe = drive_reg & ~cs_n & hold_n;
  assign so_o  = so_reg;

  // Pin and frame-toggle synchronisers on the system clock.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cs_s1_reg  <= 1'b1;
      cs_s2_reg  <= 1'b1;
      cs_s3_reg  <= 1'b1;
      wp_s1_reg  <= 1'b0;
      wp_s2_reg  <= 1'b0;
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
    end
    else
    begin
      cs_s1_reg  <= cs_n;
      cs_s2_reg  <= cs_s1_reg;
      cs_s3_reg  <= cs_s2_reg;
      wp_s1_reg  <= wp_n;
      wp_s2_reg  <= wp_s1_reg;
      tog_s1_reg <= tog_reg;
      tog_s2_reg <= tog_s1_reg;
    end
  end

  // A frame is committed once, at its closing chip select edge.
  always_ff @(posedge clk)
  begin
    if (reset)
      tog_seen_reg <= 1'b0;
    else if (cs_s2_reg && !cs_s3_reg)
      tog_seen_reg <= tog_s2_reg;
  end
  assign commit = cs_s2_reg & ~cs_s3_reg & (tog_s2_reg != tog_seen_reg);

  // Protection decode for the first addressed byte.
  always_comb
  begin
    unique case (guard_reg)
      `SEPC_GUARD_NONE:  guarded = 1'b0;
      `SEPC_GUARD_QUART: guarded = &start_reg[ADDR_W-1:ADDR_W-2];
      `SEPC_GUARD_HALF:  guarded = start_reg[ADDR_W-1];
      `SEPC_GUARD_FULL:  guarded = 1'b1;
    endcase
  end

  assign wr_ok    = wl_reg & wp_s2_reg & ~busy_reg;
  assign write_go = commit & (kind_reg == sepc_pkg::K_WRITE) & wr_ok &
                    aligned_reg & (|mask_reg) & ~guarded &
                    (idsel_reg | lock_reg);
  assign stat_go  = commit & (kind_reg == sepc_pkg::K_WR_STAT) & wr_ok &
                    aligned_reg;
  assign prog_done = busy_reg & (cnt_reg == '0);

  // Programming timer; busy covers the whole cycle.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busy_reg <= 1'b0;
      cnt_reg  <= '0;
    end
    else if (write_go || stat_go)
    begin
      busy_reg <= 1'b1;
      cnt_reg  <= CW'(PROG_CYCLES - 1);
    end
    else if (prog_done)
      busy_reg <= 1'b0;
    else if (busy_reg)
      cnt_reg <= cnt_reg - CW'(1);
  end

  // Write latch.
  always_ff @(posedge clk)
  begin
    if (reset)
      wl_reg <= 1'b0;
    else if (prog_done)
      wl_reg <= 1'b0;
    else if (commit && !busy_reg && kind_reg == sepc_pkg::K_SET_WL &&
             aligned_reg)
      wl_reg <= 1'b1;
    else if (commit && !busy_reg && kind_reg == sepc_pkg::K_CLR_WL &&
             aligned_reg)
      wl_reg <= 1'b0;
  end

  // Guard, lock and id-page select fields.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      guard_reg <= `SEPC_GUARD_RST;
      lock_reg  <= `SEPC_LOCK_RST;
      idsel_reg <= `SEPC_IDSEL_RST;
    end
    else if (stat_go)
    begin
      guard_reg <= {sr_data_reg[`SEPC_SR_GUARD_HI],
                    sr_data_reg[`SEPC_SR_GUARD_LO]};
      if (sr_data_reg[`SEPC_SR_IDSEL] || sr_data_reg[`SEPC_SR_LOCK])
      begin
        idsel_reg <= sr_data_reg[`SEPC_SR_IDSEL];
        lock_reg  <= lock_reg & sr_data_reg[`SEPC_SR_LOCK];
      end
    end
    else if (commit && !busy_reg && (kind_reg == sepc_pkg::K_WRITE ||
             kind_reg == sepc_pkg::K_READ))
      idsel_reg <= 1'b1;
  end

  // Array or id page programming from the page buffer at launch, chosen by idsel.
  always_ff @(posedge clk)
  begin
    if (write_go)
    begin
      for (int j = 0; j < `SEPC_PAGE_BYTES; j++)
      begin
        if (mask_reg[j] && idsel_reg)
          mem_arr[{start_reg[ADDR_W-1:PB], PB'(j)}] <= page_buf[j];
        else if (mask_reg[j])
          id_arr[j] <= page_buf[j];
      end
    end
  end

endmodule

// ==== tb/sepc_command_protect_chk.sv ====
// Checker of the serial port timing of the command and protection block.
// Assumes sck is slow enough for clk to see every level of it.
`timescale 1ns/1ps
module sepc_chk #(
  parameter int ADDR_W      = 9,
  parameter int PROG_CYCLES = 20
) (
  // System clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Serial link and control pins.
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic wp_n,
  input wire logic hold_n
);
  logic       sck_reg;
  logic [5:0] cnt_reg;
  logic [7:0] op_reg;
  logic       rise;

  // An accepted rising sck edge, seen in the clk domain.
  assign rise = sck & ~sck_reg & ~cs_n & hold_n;

  // Follows sck one clk cycle late.
  always_ff @(posedge clk)
  begin
    sck_reg <= reset ? 1'b0 : sck;
  end

  // Counts accepted rising edges of the current frame.
  always_ff @(posedge clk)
  begin
    if (reset || cs_n)
      cnt_reg <= 6'h0;
    else if (rise && cnt_reg != 6'h3f)
      cnt_reg <= cnt_reg + 6'h1;
  end

  // Collects the first eight bits of the frame.
  always_ff @(posedge clk)
  begin
    if (reset)
      op_reg <= 8'h0;
    else if (rise && cnt_reg < 6'h8)
      op_reg <= {op_reg[6:0], si};
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // The output drives only when selected, unpaused and in an answer phase.
  AST_CS_FLOAT: assert property (cs_n |-> !so_oe)
    else $error("so driven while deselected");
  AST_HOLD_FLOAT: assert property (!hold_n |-> !so_oe)
    else $error("so driven while paused");
  AST_SO_ON_FALL: assert property (
    so_oe && $past(so_oe) && $changed(so_o) |-> !sck)
    else $error("so changed while sck high");
  AST_OPCODE_FIRST: assert property (
    !cs_n && cnt_reg < 6'h8 |-> !so_oe)
    else $error("so driven before the opcode ended");
  AST_OE_CMD: assert property ($rose(so_oe) |-> cnt_reg >= 6'h8 &&
    (op_reg == 8'h05 || (op_reg & 8'hf7) == 8'h03))
    else $error("so driven for a command without output");
  AST_READ_ADDR: assert property (
    $rose(so_oe) && op_reg != 8'h05 |-> cnt_reg >= 6'h10)
    else $error("read data before the address ended");
  AST_OE_HOLDS: assert property (
    so_oe && !cs_n && hold_n |=> so_oe || cs_n || !hold_n)
    else $error("output dropped inside a frame");
  AST_STATUS_ONES: assert property (rise && op_reg == 8'h05 &&
    cnt_reg >= 6'h8 && (cnt_reg[2:0] == 3'h0 || cnt_reg[2:0] == 3'h2)
    |-> so_oe && so_o)
    else $error("status bit 7 or 5 not one");
  AST_STATUS_PROMPT: assert property (rise && cnt_reg == 6'h7 &&
    {op_reg[6:0], si} == 8'h05 |-> ##[1:4] so_oe)
    else $error("status output late");

  // Main scenarios reached.
  COV_STATUS: cover property (rise && op_reg == 8'h05 && cnt_reg == 6'h8);
  COV_READ: cover property ($rose(so_oe) && op_reg != 8'h05);
  COV_PAUSE: cover property (!hold_n && !cs_n);
endmodule

bind sepc_command_protect sepc_chk #(
  .ADDR_W      (ADDR_W),
  .PROG_CYCLES (PROG_CYCLES)
) u_chk (
  .clk    (clk),
  .reset  (reset),
  .sck    (sck),
  .cs_n   (cs_n),
  .si     (si),
  .so_o   (so_o),
  .so_oe  (so_oe),
  .wp_n   (wp_n),
  .hold_n (hold_n)
);

// ==== tb/sepc_host_model.sv ====
// Host controller model of the serial link, framing each command.
// Assumes the device samples on rising sck and shifts on falling sck.
`timescale 1ns/1ps
module sepc_host_model (
  // Serial link towards the device.
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  input  wire logic so_o,
  input  wire logic so_oe,
  // Clock that frames are aligned to.
  input  wire logic clk
);
  localparam int HALF = 32;
  logic [15:0] rx;
  logic        oe_seen;

  // Idle link: deselected, not paused, clock standing still.
  // Select rises after every process has started, so the device sees an
  // edge that clears its frame state before the first command.
  initial
  begin
    sck     = 1'b0;
    cs_n    <= 1'b1;
    si      = 1'b0;
    hold_n  = 1'b1;
    rx      = 16'h0;
    oe_seen = 1'b0;
  end

  // Sends ntx bytes of tx, reads nrx bytes, pauses before bit pause_at.
  task automatic frame(input logic [39:0] tx, input int ntx, input int nrx,
                       input bit mode3, input int pause_at);
    int nbit;
    nbit = 8 * (ntx + nrx);
    rx = 16'h0;
    oe_seen = 1'b0;
    @(posedge clk);
    #7 sck <= mode3;
    #(HALF) cs_n <= 1'b0;
    #(HALF);
    for (int i = 0; i < nbit; i++)
    begin
      sck <= 1'b0;
      si <= (i < 8 * ntx) ? tx[39 - i] : ~si;
      if (i == pause_at)
      begin
        #(HALF) hold_n <= 1'b0;
        #(HALF) sck <= 1'b1;
        si <= ~si;
        #(HALF) sck <= 1'b0;
        si <= ~si;
        #(HALF) hold_n <= 1'b1;
      end
      #(HALF) sck <= 1'b1;
      #1;
      oe_seen = oe_seen | so_oe;
      // An undriven line reads as the inverse, so a float cannot pass.
      if (i >= 8 * ntx)
        rx = {rx[14:0], so_oe ? so_o : ~so_o};
      #(HALF - 1);
    end
    sck <= mode3;
    #(HALF) cs_n <= 1'b1;
    #(4 * HALF);
  endtask
endmodule

// ==== tb/sepc_command_protect_test.sv ====
// Self-checking bench of the command and protection block.
// Assumes the host model frames all traffic and the checker is bound.
`timescale 1ns/1ps
module sepc_command_protect_test;
  localparam int PROG = 250;
  logic       clk;
  logic       reset;
  logic       wp_n;
  logic       sck;
  logic       cs_n;
  logic       si;
  logic       hold_n;
  logic       so_o;
  logic       so_oe;
  logic [7:0] mem [0:3];
  logic [8:0] probe [0:3] = '{9'h0ff, 9'h100, 9'h17f, 9'h180};
  logic [7:0] bad [0:2] = '{8'h07, 8'hff, 8'h85};
  int         n_errors;
  int         num_checks;

  // Device with a short programming time.
  sepc_command_protect #(
    .ADDR_W      (9),
    .PROG_CYCLES (PROG)
  ) dut (
    .clk    (clk),
    .reset  (reset),
    .sck    (sck),
    .cs_n   (cs_n),
    .si     (si),
    .so_o   (so_o),
    .so_oe  (so_oe),
    .wp_n   (wp_n),
    .hold_n (hold_n)
  );

  // Host on the far side of the serial link.
  sepc_host_model host (
    .sck    (sck),
    .cs_n   (cs_n),
    .si     (si),
    .hold_n (hold_n),
    .so_o   (so_o),
    .so_oe  (so_oe),
    .clk    (clk)
  );

  // System clock.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic send(input logic [39:0] tx, input int n);
    host.frame(tx, n, 0, 1'b0, -1);
  endtask

  task automatic status(input logic [7:0] exp);
    host.frame({8'h05, 32'h0}, 1, 1, 1'b0, -1);
    check(host.rx, {8'h00, exp});
  endtask

  task automatic rd(input logic [8:0] a, input int n, input logic [15:0] e);
    host.frame({4'h0, a[8], 3'h3, a[7:0], 24'h0}, 2, n, 1'b0, -1);
    check(host.rx, e);
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    send({8'h06, 32'h0}, 1);
    send({4'h0, a[8], 3'h2, a[7:0], d, 16'h0}, 3);
  endtask

  // Polls the busy bit a bounded number of times.
  task automatic wait_ready();
    int k;
    k = 0;
    host.frame({8'h05, 32'h0}, 1, 1, 1'b0, -1);
    while (host.rx[0] !== 1'b0)
    begin
      k++;
      if (k == 50)
      begin
        n_errors++;
        $display("[FAIL] %0t device stays busy", $time);
        conclude();
      end
      host.frame({8'h05, 32'h0}, 1, 1, 1'b0, -1);
    end
  endtask

  task automatic cmd_write_status(input logic [7:0] d);
    send({8'h06, 32'h0}, 1);
    send({8'h01, d, 24'h0}, 2);
    wait_ready();
  endtask

  function automatic logic guarded(input logic [8:0] a, input logic [1:0] g);
    return g == 2'h3 || (g == 2'h2 && a[8]) || (g == 2'h1 && a[8:7] == 2'h3);
  endfunction

  // Main sequence of scenarios.
  initial
  begin
    n_errors = 0;
    num_checks = 0;
    // Reset rises after every process has started, so the asynchronous
    // reset of the serial-side frame results sees its edge.
    reset <= 1'b1;
    wp_n <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (17500) @(posedge clk);
    status(8'hf0);
    host.frame({8'h06, 32'h0}, 1, 0, 1'b1, -1);
    status(8'hf2);
    send({8'h04, 32'h0}, 1);
    status(8'hf0);
    send({8'h06, 32'h0}, 2);
    status(8'hf0);
    foreach (bad[i])
    begin
      host.frame({bad[i], 32'h0}, 2, 1, 1'b0, -1);
      check({15'h0, host.oe_seen}, 16'h0);
    end
    wr(9'h010, 8'h5a);
    send({8'h02, 8'h10, 8'ha5, 16'h0}, 3);
    status(8'hf3);
    wait_ready();
    status(8'hf0);
    rd(9'h010, 1, 16'h005a);
    send({8'h06, 32'h0}, 1);
    send({8'h0a, 8'h1f, 8'h11, 8'h22, 8'h33}, 5);
    wait_ready();
    rd(9'h11f, 1, 16'h0011);
    rd(9'h110, 2, 16'h2233);
    rd(9'h010, 1, 16'h005a);
    @(posedge clk) wp_n <= 1'b0;
    wr(9'h010, 8'hc3);
    status(8'hf2);
    @(posedge clk) wp_n <= 1'b1;
    rd(9'h010, 1, 16'h005a);
    for (int g = 0; g < 4; g++)
    begin
      cmd_write_status({4'h0, 2'(g), 2'h0});
      status({4'hf, 2'(g), 2'h0});
      for (int p = 0; p < 4; p++)
      begin
        wr(probe[p], 8'(8'h60 + 4 * g + p));
        wait_ready();
        if (!guarded(probe[p], 2'(g)))
          mem[p] = 8'(8'h60 + 4 * g + p);
        rd(probe[p], 1, {8'h00, mem[p]});
      end
    end
    // Busy and latch bits in the data must not stick; both id bits clear.
    cmd_write_status(8'h03);
    status(8'hf0);
    cmd_write_status(8'h10);
    status(8'hb0);
    wr(9'h003, 8'hc3);
    wait_ready();
    status(8'hf0);
    cmd_write_status(8'h10);
    rd(9'h003, 1, 16'h00c3);
    status(8'hf0);
    cmd_write_status(8'h40);
    status(8'he0);
    // A locked id page refuses writes and keeps its old content.
    cmd_write_status(8'h10);
    status(8'ha0);
    wr(9'h003, 8'h77);
    wait_ready();
    cmd_write_status(8'h10);
    rd(9'h003, 1, 16'h00c3);
    host.frame({8'h05, 32'h0}, 1, 1, 1'b0, 3);
    check(host.rx, 16'h00e0);
    conclude();
  end
endmodule
